/* File: verilog/acs_seq.sv */
// Channel sequencer and serial port of a 16-input converter.
// Assumes the host drives frame select, serial clock and data in,
// and that the analog core returns one code per conversion start.
`timescale 1ns/1ps
module acs_seq (
  input  wire logic                      clk_in,
  input  wire logic                      sys_rst_in,
  // Avalon-MM slave
  input  wire logic [acs_pkg::ADDR_W-1:0] avs_address_in,
  input  wire logic                      avs_read_in,
  input  wire logic                      avs_write_in,
  input  wire logic [31:0]               avs_writedata_in,
  input  wire logic [3:0]                avs_byteenable_in,
  output logic      [31:0]               avs_readdata_out,
  output logic                           avs_waitrequest_out,
  // Serial link pins
  input  wire logic                      converter_frame_select_n_in,
  input  wire logic                      converter_serial_clock_in,
  input  wire logic                      converter_serial_in_in,
  output logic                           converter_serial_out_out,
  output logic                           converter_serial_oe_n_out,
  // Analog core
  output logic      [3:0]                mux_channel_out,
  output logic                           span_double_out,
  output logic                           conv_start_out,
  output logic                           sar_step_out,
  input  wire logic                      code_valid_in,
  input  wire logic [11:0]               code_in,
  output logic                           code_ready_out
);
  acs_pkg::acs_link_s link_raw;
  acs_pkg::acs_link_s link_s;
  acs_pkg::acs_mode_e mode_reg;
  acs_pkg::acs_word_s push_word;
  acs_pkg::acs_word_s head_word;
  acs_pkg::acs_word_s head_word_q;
  logic        frame_d_reg;
  logic        sclk_d_reg;
  logic        frame_fall;
  logic        frame_rise;
  logic        sclk_fall;
  logic        sclk_rise;
  logic        active_reg;
  logic [4:0]  bit_cnt_reg;
  logic [14:0] rx_reg;
  logic [15:0] rx_word;
  logic        word_done;
  logic [15:0] tx_reg;
  logic [3:0]  cur_ch_reg;
  logic [3:0]  last_ch_reg;
  logic [3:0]  conv_ch_reg;
  logic [15:0] shadow_reg;
  logic        range_reg;
  logic        enable_reg;
  logic [15:0] words_reg;
  logic        ack_reg;
  logic        head_valid;
  logic        head_pop;
  logic [1:0]  seq_bits;

  // Lowest selected channel above cur, else the lowest selected one
  function automatic logic [3:0] next_ch(input logic [15:0] mask,
                                         input logic [3:0]  cur);
    logic [3:0] pick;
    logic       found;
    pick  = acs_pkg::FIRST_CH;
    found = 1'b0;
    for (int i = acs_pkg::NUM_CH - 1; i >= 0; i--) begin
      if (mask[i] && (4'(i) > cur)) begin
        pick  = 4'(i);
        found = 1'b1;
      end
    end
    if (!found) begin
      for (int i = acs_pkg::NUM_CH - 1; i >= 0; i--) begin
        if (mask[i]) begin
          pick = 4'(i);
        end
      end
    end
    return pick;
  endfunction

  // Mask of channels 0 up to and including last
  function automatic logic [15:0] upto_mask(input logic [3:0] last);
    logic [15:0] m;
    m = '0;
    for (int i = 0; i < acs_pkg::NUM_CH; i++) begin
      m[i] = (4'(i) <= last);
    end
    return m;
  endfunction

  // Link pins pass two flops before use
  assign link_raw = '{frame_n: converter_frame_select_n_in,
                      sclk:    converter_serial_clock_in,
                      din:     converter_serial_in_in};

  acs_sync #(
    .W (3)
  ) u_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .d_in       (link_raw),
    .q_out      (link_s)
  );

  // Edge detection on synchronised pins
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      frame_d_reg <= 1'b0; // Matches the synchroniser's reset output, so no false fall
      sclk_d_reg  <= 1'b0;
    end else begin
      frame_d_reg <= link_s.frame_n;
      sclk_d_reg  <= link_s.sclk;
    end
  end

  assign frame_fall = frame_d_reg & ~link_s.frame_n;
  assign frame_rise = ~frame_d_reg & link_s.frame_n;
  assign sclk_fall  = sclk_d_reg & ~link_s.sclk;
  assign sclk_rise  = ~sclk_d_reg & link_s.sclk;
  assign rx_word    = {rx_reg, link_s.din};
  assign word_done  = active_reg & sclk_fall & (bit_cnt_reg == acs_pkg::LAST_BIT);
  assign seq_bits   = {rx_word[acs_pkg::F_SEQ], rx_word[acs_pkg::F_SHADOW]};

  // Frame tracking and bit count
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      active_reg  <= 1'b0;
      bit_cnt_reg <= 5'h00;
    end else if (frame_fall && enable_reg) begin
      active_reg  <= 1'b1;
      bit_cnt_reg <= 5'h00;
    end else if (frame_rise || word_done) begin
      active_reg  <= 1'b0;
    end else if (active_reg && sclk_fall) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  // Control data shifts in on serial clock falls
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rx_reg <= '0;
    end else if (active_reg && sclk_fall) begin
      rx_reg <= rx_word[14:0];
    end
  end

  // Result word shifts out, first bit at the frame fall
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      tx_reg                    <= '0;
      converter_serial_out_out  <= 1'b0;
      converter_serial_oe_n_out <= 1'b1;
    end else if (frame_fall && enable_reg) begin
      tx_reg                    <= {head_word[14:0], 1'b0};
      converter_serial_out_out  <= head_word[15];
      converter_serial_oe_n_out <= 1'b0;
    end else if (active_reg && sclk_fall) begin
      tx_reg                    <= {tx_reg[14:0], 1'b0};
      converter_serial_out_out  <= tx_reg[15];
    end else if (frame_rise) begin
      converter_serial_oe_n_out <= 1'b1;
    end
  end

  // Empty buffer sends the channel about to convert with a zero code
  assign head_word = head_valid ? head_word_q : acs_pkg::acs_word_s'{ch: cur_ch_reg, code: '0};
  // Pop happens with the load of the outgoing word
  assign head_pop  = frame_fall & enable_reg;

  // Conversion start and successive approximation steps
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      conv_start_out <= 1'b0;
      sar_step_out   <= 1'b0;
      conv_ch_reg    <= acs_pkg::FIRST_CH;
    end else begin
      conv_start_out <= frame_fall & enable_reg;
      sar_step_out   <= active_reg & sclk_rise;
      if (frame_fall && enable_reg) begin
        conv_ch_reg <= cur_ch_reg;
      end
    end
  end

  // Core output gets its channel tag and coding
  always_comb begin
    push_word.ch   = conv_ch_reg;
    push_word.code = range_reg ? (code_in ^ acs_pkg::TWOS_FLIP) : code_in;
  end

  acs_buf2 #(
    .DW (acs_pkg::WORD_W)
  ) u_buf (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .in_valid_in   (code_valid_in),
    .in_data_in    (push_word),
    .in_ready_out  (code_ready_out),
    .out_valid_out (head_valid),
    .out_data_out  (head_word_q),
    .out_ready_in  (head_pop)
  );

  // Analog routing
  assign mux_channel_out = cur_ch_reg;
  assign span_double_out = range_reg;

  // Sequencer acts on each complete received word
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mode_reg    <= acs_pkg::ACS_SINGLE;
      cur_ch_reg  <= acs_pkg::FIRST_CH;
      last_ch_reg <= acs_pkg::TOP_CH;
      shadow_reg  <= '0;
      range_reg   <= 1'b0;
    end else if (word_done) begin
      if (mode_reg == acs_pkg::ACS_ARM) begin
        shadow_reg <= rx_word;
        mode_reg   <= acs_pkg::ACS_LIST;
        cur_ch_reg <= next_ch(rx_word, acs_pkg::TOP_CH);
      end else if (rx_word[acs_pkg::F_WRITE]) begin
        range_reg <= rx_word[acs_pkg::F_RANGE];
        case (seq_bits)
          acs_pkg::SEQ_ARM: begin
            mode_reg   <= acs_pkg::ACS_ARM;
            cur_ch_reg <= rx_word[acs_pkg::F_ADDR_HI:acs_pkg::F_ADDR_LO];
          end
          acs_pkg::SEQ_CONSEC: begin
            mode_reg    <= acs_pkg::ACS_CONSEC;
            last_ch_reg <= rx_word[acs_pkg::F_ADDR_HI:acs_pkg::F_ADDR_LO];
            cur_ch_reg  <= acs_pkg::FIRST_CH;
          end
          acs_pkg::SEQ_KEEP: begin
            if (mode_reg == acs_pkg::ACS_LIST) begin
              cur_ch_reg <= next_ch(shadow_reg, cur_ch_reg);
            end else if (mode_reg == acs_pkg::ACS_CONSEC) begin
              cur_ch_reg <= next_ch(upto_mask(last_ch_reg), cur_ch_reg);
            end else begin
              cur_ch_reg <= rx_word[acs_pkg::F_ADDR_HI:acs_pkg::F_ADDR_LO];
            end
          end
          default: begin
            mode_reg   <= acs_pkg::ACS_SINGLE;
            cur_ch_reg <= rx_word[acs_pkg::F_ADDR_HI:acs_pkg::F_ADDR_LO];
          end
        endcase
      end else begin
        case (mode_reg)
          acs_pkg::ACS_LIST: begin
            cur_ch_reg <= next_ch(shadow_reg, cur_ch_reg);
          end
          acs_pkg::ACS_CONSEC: begin
            cur_ch_reg <= next_ch(upto_mask(last_ch_reg), cur_ch_reg);
          end
          default: begin
            cur_ch_reg <= cur_ch_reg;
          end
        endcase
      end
    end
  end

  // Count of complete words received
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      words_reg <= '0;
    end else if (word_done) begin
      words_reg <= words_reg + 16'h0001;
    end
  end

  // Avalon slave: one wait state per access
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_reg;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read_in | avs_write_in) & ~ack_reg;
    end
  end

  // Configuration write takes effect with the answer
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      enable_reg <= acs_pkg::CFG_EN_RST;
    end else if (avs_write_in && ack_reg && avs_byteenable_in[0] &&
                 (avs_address_in == acs_pkg::REG_CFG)) begin
      enable_reg <= avs_writedata_in[acs_pkg::CFG_EN];
    end
  end

  // Read data, zero for unmapped addresses
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      avs_readdata_out <= '0;
    end else if (avs_read_in && !ack_reg) begin
      case (avs_address_in)
        acs_pkg::REG_CFG:    avs_readdata_out <= {31'h0, enable_reg};
        acs_pkg::REG_STATUS: avs_readdata_out <= {16'h0, 2'(mode_reg), 1'b0, active_reg,
                                                  last_ch_reg, cur_ch_reg, 3'h0, range_reg};
        acs_pkg::REG_SHADOW: avs_readdata_out <= {16'h0, shadow_reg};
        acs_pkg::REG_WORDS:  avs_readdata_out <= {16'h0, words_reg};
        default:             avs_readdata_out <= '0;
      endcase
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  AST_CODING: assert property (code_valid_in && range_reg |-> push_word.code == (code_in ^ 12'h800))
    else $error("twos complement coding wrong");
  AST_SINGLE: assert property (word_done && mode_reg != acs_pkg::ACS_ARM && rx_word[15] && seq_bits == 2'h0
    |=> mux_channel_out == $past(rx_word[13:10]) && mode_reg == acs_pkg::ACS_SINGLE)
    else $error("single channel not routed");
  AST_ARM: assert property (word_done && mode_reg != acs_pkg::ACS_ARM && rx_word[15] && seq_bits == 2'h1
    |=> mode_reg == acs_pkg::ACS_ARM)
    else $error("shadow load not armed");
  AST_FIRST: assert property (word_done && mode_reg == acs_pkg::ACS_ARM
    |=> cur_ch_reg == next_ch(shadow_reg, 4'hf) && mode_reg == acs_pkg::ACS_LIST)
    else $error("sequence does not start at lowest channel");
  AST_ADVANCE: assert property (word_done && !rx_word[15] && mode_reg == acs_pkg::ACS_LIST
    |=> cur_ch_reg == next_ch(shadow_reg, $past(cur_ch_reg)) && mode_reg == acs_pkg::ACS_LIST)
    else $error("sequence did not advance");
  AST_KEEP: assert property (word_done && rx_word[15] && seq_bits == 2'h2 && mode_reg == acs_pkg::ACS_LIST
    |=> mode_reg == acs_pkg::ACS_LIST)
    else $error("sequence interrupted by keep write");
  AST_END: assert property (word_done && rx_word[15] && seq_bits == 2'h0 && mode_reg == acs_pkg::ACS_LIST
    |=> mode_reg == acs_pkg::ACS_SINGLE)
    else $error("sequence not ended");
  AST_CONSEC: assert property (word_done && mode_reg != acs_pkg::ACS_ARM && rx_word[15] && seq_bits == 2'h3
    |=> cur_ch_reg == 4'h0 && last_ch_reg == $past(rx_word[13:10]))
    else $error("consecutive mode not from channel zero");
  AST_WRAP: assert property (word_done && !rx_word[15] && mode_reg == acs_pkg::ACS_CONSEC
    && cur_ch_reg == last_ch_reg |=> cur_ch_reg == 4'h0)
    else $error("consecutive mode did not wrap");
  AST_TAG: assert property (frame_fall && enable_reg && head_valid
    |=> converter_serial_out_out == $past(head_word_q.ch[3]) && !converter_serial_oe_n_out)
    else $error("channel tag not first out");
  AST_START: assert property (frame_fall && enable_reg |=> conv_start_out ##1 !conv_start_out)
    else $error("conversion start missing");
  AST_STEP: assert property (active_reg && sclk_rise |=> sar_step_out)
    else $error("conversion step missing");
endmodule

/* File: inc/acs_pkg.sv */
// Constants and types shared by the converter channel sequencer.
// Assumes a 200 MHz system clock and a host-driven serial link.
package acs_pkg;
  localparam int         CH_W       = 4;
  localparam int         CODE_W     = 12;
  localparam int         WORD_W     = 16;
  localparam int         NUM_CH     = 16;
  localparam logic [4:0] LAST_BIT   = 5'h0f;
  // Control word fields
  localparam int         F_WRITE    = 15;
  localparam int         F_SEQ      = 14;
  localparam int         F_ADDR_HI  = 13;
  localparam int         F_ADDR_LO  = 10;
  localparam int         F_SHADOW   = 9;
  localparam int         F_RANGE    = 0;
  localparam logic [1:0] SEQ_SINGLE = 2'h0;
  localparam logic [1:0] SEQ_ARM    = 2'h1;
  localparam logic [1:0] SEQ_KEEP   = 2'h2;
  localparam logic [1:0] SEQ_CONSEC = 2'h3;
  // Result coding and channel limits
  localparam logic [11:0] TWOS_FLIP = 12'h800;
  localparam logic [3:0]  FIRST_CH  = 4'h0;
  localparam logic [3:0]  TOP_CH    = 4'hf;
  // Register map, byte addresses
  localparam int         ADDR_W     = 4;
  localparam logic [3:0] REG_CFG    = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_SHADOW = 4'h8;
  localparam logic [3:0] REG_WORDS  = 4'hc;
  localparam int         CFG_EN     = 0;
  localparam logic       CFG_EN_RST = 1'b1;

  typedef enum {
    ACS_SINGLE,
    ACS_ARM,
    ACS_LIST,
    ACS_CONSEC
  } acs_mode_e;

  // One result word as it leaves on the link
  typedef struct packed {
    logic [3:0]  ch;
    logic [11:0] code;
  } acs_word_s;

  // Link pins as sampled
  typedef struct packed {
    logic frame_n;
    logic sclk;
    logic din;
  } acs_link_s;
endpackage

/* File: verilog/acs_sync.sv */
// Two-stage synchroniser for a group of asynchronous inputs.
// Assumes the inputs change slowly against clk_in.
`timescale 1ns/1ps
module acs_sync #(
  parameter int W = 3
) (
  input  wire logic         clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      meta_reg <= '0;
      q_out    <= '0;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule

/* File: verilog/acs_buf2.sv */
// Two-entry buffer with valid and ready on both sides.
// Assumes both sides run on clk_in.
`timescale 1ns/1ps
module acs_buf2 #(
  parameter int DW = 16
) (
  input  wire logic          clk_in,
  input  wire logic          sys_rst_in,
  input  wire logic          in_valid_in,
  input  wire logic [DW-1:0] in_data_in,
  output logic               in_ready_out,
  output logic               out_valid_out,
  output logic      [DW-1:0] out_data_out,
  input  wire logic          out_ready_in
);
  logic [DW-1:0] mem_reg [2];
  logic          wr_ptr_reg;
  logic          rd_ptr_reg;
  logic [1:0]    count_reg;
  logic          push;
  logic          pop;

  // Full and empty come straight from the count
  assign in_ready_out  = (count_reg != 2'h2);
  assign out_valid_out = (count_reg != 2'h0);
  assign out_data_out  = mem_reg[rd_ptr_reg];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  // Storage and pointers
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= in_data_in;
        wr_ptr_reg          <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

/* File: sim/acs_host_model.sv */
// Host serial master model for the converter sequencer link.
// Assumes the sequencer samples these pins with its own clock.
`timescale 1ns/1ps
module acs_host_model #(
  parameter realtime HALF = 24.0
) (
  input  wire logic so_in,
  output logic      frame_n_out,
  output logic      sclk_out,
  output logic      din_out
);
  // Idle: frame high, clock parked high
  initial begin
    frame_n_out = 1'b1;
    sclk_out    = 1'b1;
    din_out     = 1'b0;
  end

  // One framed transfer, MSB first; fewer than 16 falls aborts the word
  task automatic xfer(input logic [15:0] w, input int nbits, output logic [15:0] r);
    r           = 16'h0000;
    din_out     = w[15];
    frame_n_out = 1'b0;                  // Frame fall starts one conversion
    #(HALF);
    for (int i = 15; i > 15 - nbits; i--) begin
      r[i]     = so_in;                  // Bit stands until this fall
      sclk_out = 1'b0;                   // Falls shift data, rises step the converter
      #(HALF);
      sclk_out = 1'b1;
      din_out  = (i > 0) ? w[i-1] : ~w[0]; // After the last bit the line no longer holds it
      #(HALF);
    end
    frame_n_out = 1'b1;
    din_out     = ~din_out;
    #(2*HALF);
  endtask
endmodule

/* File: sim/acs_seq_tb.sv */
// Self-checking bench for the converter channel sequencer.
// Assumes the host model on the link and a tagged-code stand-in for the core.
`timescale 1ns/1ps
module acs_seq_tb;
  logic        clk_in      = 1'b0;
  logic        sys_rst_in  = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read    = 1'b0;
  logic        avs_write   = 1'b0;
  logic [31:0] avs_wdata   = 32'h0;
  logic [31:0] avs_rdata;
  logic        avs_wait;
  logic        frame_n, sclk, din, so, so_oe_n, span, conv_start, sar_step, code_ready;
  logic [3:0]  mux_ch;
  logic        code_valid  = 1'b0;
  logic [11:0] code        = 12'h000;
  logic [3:0]  conv_ch     = 4'h0;
  int          conv_cnt    = 0;
  int          step_cnt    = 0;
  int          fail_count  = 0;
  int          tests_run   = 0;
  logic [15:0] prev_word   = 16'h0000;
  logic        word_ok     = 1'b1;
  logic        cur_range   = 1'b0;
  logic [31:0] rd;
  logic [15:0] r;

  always #2.5 clk_in = ~clk_in;

  acs_seq DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(avs_address),
    .avs_read_in(avs_read), .avs_write_in(avs_write), .avs_writedata_in(avs_wdata),
    .avs_byteenable_in(4'hf), .avs_readdata_out(avs_rdata), .avs_waitrequest_out(avs_wait),
    .converter_frame_select_n_in(frame_n), .converter_serial_clock_in(sclk),
    .converter_serial_in_in(din), .converter_serial_out_out(so), .converter_serial_oe_n_out(so_oe_n),
    .mux_channel_out(mux_ch), .span_double_out(span), .conv_start_out(conv_start),
    .sar_step_out(sar_step), .code_valid_in(code_valid), .code_in(code), .code_ready_out(code_ready));

  acs_host_model HOST (.so_in(so), .frame_n_out(frame_n), .sclk_out(sclk), .din_out(din));

  // Core stand-in: code tagged by channel, held until the buffer takes it
  always @(posedge clk_in) begin
    if (conv_start) begin
      conv_ch    <= mux_ch;
      conv_cnt   <= conv_cnt + 1;
      code_valid <= 1'b1;
      code       <= {mux_ch, 8'h3c};
    end else if (code_valid && code_ready) begin
      code_valid <= 1'b0;
      code       <= ~code;
    end
    if (sar_step) step_cnt <= step_cnt + 1;
  end

  task automatic check(input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // Avalon access: request held until waitrequest is sampled low
  task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rdat);
    @(posedge clk_in);
    avs_address <= a;
    avs_wdata   <= wd;
    avs_write   <= wr;
    avs_read    <= ~wr;
    do @(posedge clk_in); while (avs_wait !== 1'b0);
    rdat = avs_rdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  function automatic logic [15:0] cw(input logic wr, input logic sq, input logic [3:0] a,
                                     input logic sh, input logic rg);
    return {wr, sq, a, sh, 8'h00, rg};
  endfunction

  // One full transfer; exp_ch[4] set means the converted channel is not defined
  task automatic frame(input logic [15:0] ctrl, input logic [4:0] exp_ch);
    int c0;
    int s0;
    c0 = conv_cnt;
    s0 = step_cnt;
    HOST.xfer(ctrl, 16, r);
    if (word_ok) check(prev_word, r);
    if (!exp_ch[4]) check(exp_ch[3:0], conv_ch);
    check(c0 + 1, conv_cnt);
    // The rise after the last fall comes once the word has closed, so it steps nothing
    check(s0 + acs_pkg::WORD_W - 1, step_cnt);
    word_ok   = !exp_ch[4];
    prev_word = {exp_ch[3:0], {exp_ch[3:0], 8'h3c} ^ (cur_range ? 12'h800 : 12'h000)};
    if (ctrl[15]) cur_range = ctrl[0];
    check(cur_range, span);
  endtask

  task automatic t_reset;
    avs(1'b0, 4'h0, 32'h0, rd); check(32'h1, rd);
    avs(1'b0, 4'h4, 32'h0, rd); check(32'h0000_0f00, rd);
    avs(1'b0, 4'h8, 32'h0, rd); check(32'h0, rd);
    avs(1'b1, 4'h2, 32'hffff_ffff, rd);
    avs(1'b0, 4'h2, 32'h0, rd); check(32'h0, rd);
    check(4'h0, mux_ch);
    check(1'b1, so_oe_n);
    $display("test reset done");
  endtask

  task automatic t_single;
    frame(cw(1'b1, 1'b0, 4'h5, 1'b0, 1'b0), 5'h00);
    frame(cw(1'b1, 1'b0, 4'hf, 1'b0, 1'b1), 5'h05);
    frame(16'h0000, 5'h0f);
    frame(cw(1'b1, 1'b0, 4'h0, 1'b0, 1'b0), 5'h0f);
    frame(16'h0000, 5'h00);
    $display("test single done");
  endtask

  task automatic t_shadow;
    frame(cw(1'b1, 1'b0, 4'h0, 1'b1, 1'b0), 5'h00);
    frame(16'h2412, 5'h10);
    avs(1'b0, 4'h8, 32'h0, rd); check(32'h2412, rd);
    frame(16'h0000, 5'h01);
    frame(16'h0000, 5'h04);
    frame(16'h0000, 5'h0a);
    frame(cw(1'b1, 1'b1, 4'h0, 1'b0, 1'b0), 5'h0d);
    frame(16'h0000, 5'h01);
    frame(16'h0000, 5'h04);
    frame(cw(1'b1, 1'b0, 4'h9, 1'b0, 1'b0), 5'h0a);
    frame(16'h0000, 5'h09);
    $display("test shadow done");
  endtask

  task automatic t_consec;
    frame(cw(1'b1, 1'b1, 4'h3, 1'b1, 1'b0), 5'h09);
    frame(16'h0000, 5'h00);
    frame(16'h0000, 5'h01);
    frame(16'h0000, 5'h02);
    frame(cw(1'b1, 1'b1, 4'h0, 1'b0, 1'b0), 5'h03);
    frame(16'h0000, 5'h00);
    frame(16'h0000, 5'h01);
    frame(16'h0000, 5'h02);
    frame(16'h0000, 5'h03);
    frame(cw(1'b1, 1'b0, 4'h2, 1'b0, 1'b0), 5'h00);
    frame(16'h0000, 5'h02);
    $display("test consecutive done");
  endtask

  // Aborted word leaves control alone; disabled port ignores frames
  task automatic t_abort;
    HOST.xfer(cw(1'b1, 1'b0, 4'h7, 1'b0, 1'b1), 8, r);
    check(4'h2, mux_ch);
    check(1'b0, span);
    avs(1'b1, 4'h0, 32'h0, rd);
    HOST.xfer(cw(1'b1, 1'b0, 4'h7, 1'b0, 1'b1), 16, r);
    check(4'h2, mux_ch);
    avs(1'b1, 4'h0, 32'h1, rd);
    check(1'b1, so_oe_n);
    frame(16'h0000, 5'h02);
    $display("test abort done");
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #400us;
    fail_count++;
    close_out;
  end

  initial begin
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    t_reset;
    t_single;
    t_shadow;
    t_consec;
    t_abort;
    close_out;
  end
endmodule
